// [hdl/dum_regs.vh]
// Constants for the per-channel register map of the dual UART.
// Assumes it is included once per design file that needs the map.
`ifndef DUM_REGS_VH
`define DUM_REGS_VH

// ****************************************************************
// Register offsets on the three address lines.
// ****************************************************************
`define DUM_ADDR_HOLDING 3'h0
`define DUM_ADDR_MASK 3'h1
`define DUM_ADDR_SOURCE 3'h2
`define DUM_ADDR_FORMAT 3'h3
`define DUM_ADDR_MODEM_OUT 3'h4
`define DUM_ADDR_LINE_FLAGS 3'h5
`define DUM_ADDR_MODEM_IN 3'h6
`define DUM_ADDR_SCRATCH 3'h7

// ****************************************************************
// Special values and field positions.
// ****************************************************************
`define DUM_FORMAT_ENHANCED_KEY 8'hbf
`define DUM_FORMAT_DIV_ENABLE_BIT 7
`define DUM_FEATURES_ENH_BIT 4
`define DUM_FIFO_ENABLE_BIT 0
`define DUM_FIFO_RX_RESET_BIT 1
`define DUM_FIFO_TX_RESET_BIT 2
`define DUM_MASK_BASIC_BITS 8'h0f
`define DUM_FIFO_BASIC_BITS 8'hcf
`define DUM_FIFO_STORE_BITS 8'hf9
`define DUM_MODEM_OUT_BASIC_BITS 8'h1f
`define DUM_FRACTION_BITS 8'h3f
`define DUM_ZERO_BYTE 8'h00

// ****************************************************************
// Reset values.
// ****************************************************************
`define DUM_RESET_BYTE 8'h00

`endif

// [hdl/dum_regmap.v]
// Per-channel register file and address decode of a dual UART.
// Assumes a host on an 8-bit bus whose strobes and selects are
// synchronous to i_core_clk; the serial engines sit outside.
`include "dum_regs.vh"
`default_nettype none

// Operation
// - Each channel has its own registers; selects pick channel, address picks register.
// - Divisor enable clear: address 000 reads receive holding, writes transmit holding.
// - Divisor enable set, not key value: 000 and 001 reach divisor low/high.
// - Address 010 reaches divisor fraction with divisor enable, no key, enhanced on.
// - Divisor enable, no key, divisor zero: 000/001 read revision and identification.
// - Divisor enable clear: address 001 reaches the interrupt mask register.
// - Outside key value and fraction select, reads of 010 return interrupt source with FIFO-enabled bits.
// - Outside key value and fraction select, writes of 010 load FIFO setup with reset pulses.
// - Address 011 always reaches line format register, read and write.
// - Address 100 outside key value reaches modem output register.
// - Address 101 outside key value reads line flags, read only.
// - Address 110 outside key value reads modem input flags, read only.
// - Address 111 outside key value is a plain scratch register.
// - Key value maps enhanced features and the four flow characters.
// - Enhanced bits work and read nonzero only while enhanced enable is set.
module dum_regmap #(
  parameter [7:0] REVISION_CODE = 8'h13, // Arbitrary value.
  parameter [7:0] IDENT_CODE = 8'h5a // Arbitrary value.
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [2:0] i_addr,
  input wire i_chan_a_select_n,
  input wire i_chan_b_select_n,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire [7:0] i_data,
  output reg [7:0] o_data,
  output reg o_data_oe,
  input wire [15:0] i_rx_data,
  input wire [11:0] i_int_source,
  input wire [15:0] i_line_flags,
  input wire [15:0] i_modem_in,
  output reg [7:0] o_tx_data,
  output reg [1:0] o_tx_load,
  output reg [1:0] o_rx_read,
  output reg [1:0] o_source_read,
  output reg [1:0] o_modem_in_read,
  output reg [1:0] o_rx_fifo_reset,
  output reg [1:0] o_tx_fifo_reset,
  output wire [15:0] o_line_format,
  output wire [15:0] o_int_mask,
  output wire [15:0] o_fifo_setup,
  output wire [15:0] o_modem_out,
  output wire [15:0] o_divisor_low,
  output wire [15:0] o_divisor_high,
  output wire [15:0] o_divisor_fraction,
  output wire [15:0] o_features,
  output wire [15:0] o_resume_one,
  output wire [15:0] o_resume_two,
  output wire [15:0] o_pause_one,
  output wire [15:0] o_pause_two
);

  // ****************************************************************
  // Storage, one entry per channel.
  // ****************************************************************

  reg [7:0] format_reg [0:1];
  reg [7:0] mask_reg [0:1];
  reg [7:0] fifo_reg [0:1];
  reg [7:0] mout_reg [0:1];
  reg [7:0] scratch_reg [0:1];
  reg [7:0] div_low_reg [0:1];
  reg [7:0] div_high_reg [0:1];
  reg [7:0] div_frac_reg [0:1];
  reg [7:0] feat_reg [0:1];
  reg [7:0] res1_reg [0:1];
  reg [7:0] res2_reg [0:1];
  reg [7:0] pau1_reg [0:1];
  reg [7:0] pau2_reg [0:1];
  reg rd_prev_reg;
  reg wr_prev_reg;
  integer k;

  // Flattened views of the stored settings for the serial engines.
  assign o_line_format = {format_reg[1], format_reg[0]};
  assign o_int_mask = {mask_reg[1], mask_reg[0]};
  assign o_fifo_setup = {fifo_reg[1], fifo_reg[0]};
  assign o_modem_out = {mout_reg[1], mout_reg[0]};
  assign o_divisor_low = {div_low_reg[1], div_low_reg[0]};
  assign o_divisor_high = {div_high_reg[1], div_high_reg[0]};
  assign o_divisor_fraction = {div_frac_reg[1], div_frac_reg[0]};
  assign o_features = {feat_reg[1], feat_reg[0]};
  assign o_resume_one = {res1_reg[1], res1_reg[0]};
  assign o_resume_two = {res2_reg[1], res2_reg[0]};
  assign o_pause_one = {pau1_reg[1], pau1_reg[0]};
  assign o_pause_two = {pau2_reg[1], pau2_reg[0]};

  // ****************************************************************
  // Channel selection and decode state.
  // ****************************************************************

  // Both selects at once is treated as no access, so no channel is hit twice.
  wire sel_a = ~i_chan_a_select_n;
  wire sel_b = ~i_chan_b_select_n;
  wire selected = sel_a ^ sel_b;
  wire ch = sel_b;
  wire [7:0] fmt = format_reg[ch];
  wire enh_on = feat_reg[ch][`DUM_FEATURES_ENH_BIT];

  // Key value test, used by read and write decode alike.
  function is_key;
    input [7:0] value;
    begin
      is_key = (value == `DUM_FORMAT_ENHANCED_KEY);
    end
  endfunction

  // Masks a byte down to its basic bits unless enhanced mode is on.
  function [7:0] gate_enh;
    input [7:0] value;
    input [7:0] basic;
    input enh;
    begin
      gate_enh = enh ? value : (value & basic);
    end
  endfunction

  wire key = is_key(fmt);
  wire div_en = fmt[`DUM_FORMAT_DIV_ENABLE_BIT];
  wire div_zero = (div_low_reg[ch] == `DUM_ZERO_BYTE) &&
                  (div_high_reg[ch] == `DUM_ZERO_BYTE);
  wire frac_sel = div_en && !key && enh_on;

  // Accesses are taken on the cycle a strobe is first seen low.
  // A held strobe therefore gives one access only, so a slow host cannot
  // drain the receive side twice with a single read.
  wire rd_start = selected && !i_rd_n && rd_prev_reg;
  wire wr_start = selected && !i_wr_n && wr_prev_reg;

  // ****************************************************************
  // Read multiplexer.
  // ****************************************************************

  reg [7:0] rd_mux;
  reg [5:0] src;
  always @* begin
    src = i_int_source[ch*6 +: 6];
    rd_mux = `DUM_ZERO_BYTE;
    case (i_addr)
      `DUM_ADDR_HOLDING: begin
        if (!div_en) begin
          rd_mux = i_rx_data[ch*8 +: 8];
        end else if (!key && div_zero) begin
          rd_mux = REVISION_CODE;
        end else begin
          rd_mux = div_low_reg[ch];
        end
      end
      `DUM_ADDR_MASK: begin
        if (!div_en) begin
          rd_mux = mask_reg[ch];
        end else if (!key && div_zero) begin
          rd_mux = IDENT_CODE;
        end else begin
          rd_mux = div_high_reg[ch];
        end
      end
      `DUM_ADDR_SOURCE: begin
        if (key) begin
          rd_mux = feat_reg[ch];
        end else if (frac_sel) begin
          rd_mux = div_frac_reg[ch] & `DUM_FRACTION_BITS;
        end else begin
          // Upper two bits mirror the FIFO enable.
          rd_mux = {{2{fifo_reg[ch][`DUM_FIFO_ENABLE_BIT]}},
                    enh_on ? src[5:4] : 2'h0, src[3:0]};
        end
      end
      `DUM_ADDR_FORMAT: begin
        rd_mux = fmt;
      end
      `DUM_ADDR_MODEM_OUT: begin
        rd_mux = key ? res1_reg[ch] : mout_reg[ch];
      end
      `DUM_ADDR_LINE_FLAGS: begin
        rd_mux = key ? res2_reg[ch] : i_line_flags[ch*8 +: 8];
      end
      `DUM_ADDR_MODEM_IN: begin
        rd_mux = key ? pau1_reg[ch] : i_modem_in[ch*8 +: 8];
      end
      `DUM_ADDR_SCRATCH: begin
        rd_mux = key ? pau2_reg[ch] : scratch_reg[ch];
      end
      default: begin
        rd_mux = `DUM_ZERO_BYTE;
      end
    endcase
  end

  // ****************************************************************
  // Bus side: strobe history, read data and side-effect pulses.
  // ****************************************************************

  // Read data is captured once per strobe, so a slow host sees a stable
  // byte even while the receive side moves on underneath.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
      o_data <= `DUM_RESET_BYTE;
      o_data_oe <= 1'b0;
      o_rx_read <= 2'h0;
      o_source_read <= 2'h0;
      o_modem_in_read <= 2'h0;
    end else begin
      rd_prev_reg <= i_rd_n;
      wr_prev_reg <= i_wr_n;
      o_data_oe <= selected && !i_rd_n;
      o_rx_read <= 2'h0;
      o_source_read <= 2'h0;
      o_modem_in_read <= 2'h0;
      if (rd_start) begin
        o_data <= rd_mux;
        if (i_addr == `DUM_ADDR_HOLDING && !div_en) begin
          o_rx_read[ch] <= 1'b1;
        end
        if (i_addr == `DUM_ADDR_SOURCE && !key && !frac_sel) begin
          o_source_read[ch] <= 1'b1;
        end
        if (i_addr == `DUM_ADDR_MODEM_IN && !key) begin
          o_modem_in_read[ch] <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Register writes.
  // ****************************************************************

  // Clearing the enhanced enable also clears the enhanced bits held in the
  // mask, FIFO setup and modem output registers; the divisor fraction keeps its value.
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (k = 0; k < 2; k = k + 1) begin
        format_reg[k] <= `DUM_RESET_BYTE;
        mask_reg[k] <= `DUM_RESET_BYTE;
        fifo_reg[k] <= `DUM_RESET_BYTE;
        mout_reg[k] <= `DUM_RESET_BYTE;
        scratch_reg[k] <= `DUM_RESET_BYTE;
        div_low_reg[k] <= `DUM_RESET_BYTE;
        div_high_reg[k] <= `DUM_RESET_BYTE;
        div_frac_reg[k] <= `DUM_RESET_BYTE;
        feat_reg[k] <= `DUM_RESET_BYTE;
        res1_reg[k] <= `DUM_RESET_BYTE;
        res2_reg[k] <= `DUM_RESET_BYTE;
        pau1_reg[k] <= `DUM_RESET_BYTE;
        pau2_reg[k] <= `DUM_RESET_BYTE;
      end
      o_tx_data <= `DUM_RESET_BYTE;
      o_tx_load <= 2'h0;
      o_rx_fifo_reset <= 2'h0;
      o_tx_fifo_reset <= 2'h0;
    end else begin
      o_tx_load <= 2'h0;
      o_rx_fifo_reset <= 2'h0;
      o_tx_fifo_reset <= 2'h0;
      if (wr_start) begin
        case (i_addr)
          `DUM_ADDR_HOLDING: begin
            if (div_en) begin
              div_low_reg[ch] <= i_data;
            end else begin
              o_tx_data <= i_data;
              o_tx_load[ch] <= 1'b1;
            end
          end
          `DUM_ADDR_MASK: begin
            if (div_en) begin
              div_high_reg[ch] <= i_data;
            end else begin
              mask_reg[ch] <= gate_enh(i_data, `DUM_MASK_BASIC_BITS, enh_on);
            end
          end
          `DUM_ADDR_SOURCE: begin
            if (key) begin
              feat_reg[ch] <= i_data;
              if (!i_data[`DUM_FEATURES_ENH_BIT]) begin
                mask_reg[ch] <= mask_reg[ch] & `DUM_MASK_BASIC_BITS;
                fifo_reg[ch] <= fifo_reg[ch] & `DUM_FIFO_BASIC_BITS;
                mout_reg[ch] <= mout_reg[ch] & `DUM_MODEM_OUT_BASIC_BITS;
              end
            end else if (frac_sel) begin
              div_frac_reg[ch] <= i_data & `DUM_FRACTION_BITS;
            end else begin
              // FIFO resets are pulses; the stored copy never keeps them.
              fifo_reg[ch] <= gate_enh(i_data, `DUM_FIFO_BASIC_BITS, enh_on) &
                              `DUM_FIFO_STORE_BITS;
              o_rx_fifo_reset[ch] <= i_data[`DUM_FIFO_RX_RESET_BIT];
              o_tx_fifo_reset[ch] <= i_data[`DUM_FIFO_TX_RESET_BIT];
            end
          end
          `DUM_ADDR_FORMAT: begin
            format_reg[ch] <= i_data;
          end
          `DUM_ADDR_MODEM_OUT: begin
            if (key) begin
              res1_reg[ch] <= i_data;
            end else begin
              mout_reg[ch] <= gate_enh(i_data, `DUM_MODEM_OUT_BASIC_BITS, enh_on);
            end
          end
          `DUM_ADDR_LINE_FLAGS: begin
            // Outside the key value the line flags are read only, so the write falls away.
            if (key) begin
              res2_reg[ch] <= i_data;
            end
          end
          `DUM_ADDR_MODEM_IN: begin
            // Outside the key value the modem inputs are read only, so the write falls away.
            if (key) begin
              pau1_reg[ch] <= i_data;
            end
          end
          `DUM_ADDR_SCRATCH: begin
            if (key) begin
              pau2_reg[ch] <= i_data;
            end else begin
              scratch_reg[ch] <= i_data;
            end
          end
          default: begin
            format_reg[ch] <= format_reg[ch];
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [verif/dum_regmap_checker.sv]
// Concurrent checks on the register map ports of one dual UART.
// Assumes it is bound to dum_regmap, which has a single clock domain.
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module dum_regmap_checker (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic i_chan_a_select_n,
  input wire logic i_chan_b_select_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_data,
  input wire logic [15:0] i_rx_data,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe,
  input wire logic [7:0] o_tx_data,
  input wire logic [1:0] o_tx_load,
  input wire logic [1:0] o_rx_read,
  input wire logic [1:0] o_source_read,
  input wire logic [1:0] o_rx_fifo_reset,
  input wire logic [1:0] o_modem_in_read,
  input wire logic [1:0] o_tx_fifo_reset,
  input wire logic [15:0] o_line_format,
  input wire logic [15:0] o_int_mask,
  input wire logic [15:0] o_modem_out,
  input wire logic [15:0] o_divisor_fraction,
  input wire logic [15:0] o_divisor_low,
  input wire logic [15:0] o_features
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_q;
  logic rd_q;
  // Strobe history starts high, so a strobe low at release counts as a start.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
    end else begin
      wr_q <= i_wr_n;
      rd_q <= i_rd_n;
    end
  end
  // Decoded access starts and map state.
  wire sa = !i_chan_a_select_n && i_chan_b_select_n;
  wire sb = i_chan_a_select_n && !i_chan_b_select_n;
  wire wg = !i_wr_n && wr_q;
  wire rg = !i_rd_n && rd_q;
  wire key = o_line_format[7:0] == 8'hbf;
  wire dv = o_line_format[7];
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  fmt_write_a: assert property (
    wg && sa && i_addr == 3'h3 |=> o_line_format[7:0] == $past(i_data)) else $error("format lost");
  tx_load_a: assert property (
    wg && sa && i_addr == 3'h0 && !dv |=> o_tx_load == 2'b01 && o_tx_data == $past(i_data))
    else $error("transmit load wrong");
  rx_read_a: assert property (
    rg && sa && i_addr == 3'h0 && !dv |=> o_rx_read == 2'b01 && o_data == $past(i_rx_data[7:0]))
    else $error("receive read wrong");
  mask_write_a: assert property (
    wg && sb && i_addr == 3'h1 && !o_line_format[15] |=>
    o_int_mask[15:8] == ($past(i_data) & (o_features[12] ? 8'hff : 8'h0f))) else $error("mask");
  div_write_a: assert property (
    wg && sa && i_addr == 3'h0 && dv |=> o_divisor_low[7:0] == $past(i_data) && o_tx_load == 2'b00)
    else $error("divisor low write wrong");
  feat_write_a: assert property (
    wg && sa && i_addr == 3'h2 && key |=> o_features[7:0] == $past(i_data)) else $error("features");
  bus_drive_a: assert property (
    (rg && (sa || sb) |=> o_data_oe) and (i_rd_n |=> !o_data_oe)) else $error("drive enable");
  both_sel_a: assert property (
    !i_chan_a_select_n && !i_chan_b_select_n |=> o_tx_load == 2'b00 && o_rx_read == 2'b00)
    else $error("double select acted");
  // A write to 010 with divisor and enhanced enable set and no key value lands in the fraction, not the FIFO.
  fifo_pulse_a: assert property (
    wg && sa && i_addr == 3'h2 && !key && !(dv && o_features[4]) && i_data[1] |=>
    o_rx_fifo_reset == 2'b01 ##1 o_rx_fifo_reset == 2'b00)
    else $error("fifo reset pulse wrong");
  tx_fifo_pulse_a: assert property (
    wg && sa && i_addr == 3'h2 && !key && !(dv && o_features[4]) |=>
    o_tx_fifo_reset == {1'b0, $past(i_data[2])}) else $error("transmit fifo pulse wrong");
  modem_in_pulse_a: assert property (
    rg && sa && i_addr == 3'h6 && !key |=> o_modem_in_read == 2'b01) else $error("modem pulse");
  mout_write_a: assert property (
    wg && sa && i_addr == 3'h4 && !key |=>
    o_modem_out[7:0] == ($past(i_data) & (o_features[4] ? 8'hff : 8'h1f)))
    else $error("modem out write wrong");
  frac_write_a: assert property (
    wg && sa && i_addr == 3'h2 && dv && !key && o_features[4] |=>
    o_divisor_fraction[7:0] == ($past(i_data) & 8'h3f)) else $error("fraction write wrong");
  src_read_a: assert property (
    rg && sa && i_addr == 3'h2 && !key && !(dv && o_features[4]) |=> o_source_read == 2'b01)
    else $error("source read pulse missing");
  cover property (wg && sa && key);
  cover property (rg && sa && i_addr == 3'h0 && dv);
  cover property (wg && !i_chan_a_select_n && !i_chan_b_select_n);
endmodule
`default_nettype wire

// [verif/dum_host_model.sv]
// Host processor model for the 8-bit register bus.
// Assumes the caller invokes acc from one process only.
`default_nettype none
// ****************************************************************
// Host bus model
// ****************************************************************
module dum_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  output var logic [2:0] o_addr,
  output var logic [1:0] o_cs_n,
  output var logic o_rd_n,
  output var logic o_wr_n,
  output var logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus; released lines flip so stale values are never trusted.
  initial begin
    o_addr = 3'h0;
    o_cs_n = 2'b11;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_wdata = 8'h00;
  end
  // One access: strobe for one sampled edge, then one idle cycle.
  task automatic acc(input logic wr, input logic [1:0] cs, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge i_core_clk);
    #1;
    o_cs_n = cs;
    o_addr = a;
    o_wdata = d;
    o_rd_n = wr;
    o_wr_n = !wr;
    @(posedge i_core_clk);
    #1;
    o_cs_n = 2'b11;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = ~a;
    o_wdata = ~d;
    @(posedge i_core_clk);
    q = i_rdata;
  endtask
endmodule
`default_nettype wire

// [verif/test_dual_uart_register_map.sv]
// Self-checking bench for the register map of both channels.
// Assumes the host model drives the bus and the checker is bound.
`default_nettype none
// ****************************************************************
// Bench top
// ****************************************************************
module test_dual_uart_register_map;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic wr; logic [1:0] cs; logic [2:0] a; logic [7:0] d; logic [7:0] e;} dum_row_t;
  localparam logic [1:0] A = 2'b10;
  localparam logic [1:0] B = 2'b01;
  localparam logic [1:0] N = 2'b00;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] q;
  int err_count = 0;
  int n_tests = 0;
  wire logic [2:0] addr;
  wire logic [1:0] cs_n;
  wire logic rd_n, wr_n, oe;
  wire logic [7:0] wdata, rdata;
  wire logic [15:0] fmt, feat, dll, fifo;
  // Rows: write flag, selects, address, data, expected read value.
  dum_row_t rows [46] = '{
    '{1,A,3'h3,8'h03,8'h0}, '{0,A,3'h3,8'h0,8'h03}, '{1,A,3'h7,8'ha5,8'h0},
    '{0,A,3'h7,8'h0,8'ha5}, '{1,B,3'h7,8'h3c,8'h0}, '{0,A,3'h7,8'h0,8'ha5},
    '{0,B,3'h7,8'h0,8'h3c}, '{1,N,3'h7,8'hff,8'h0}, '{0,A,3'h7,8'h0,8'ha5},
    '{1,B,3'h1,8'hff,8'h0}, '{0,B,3'h1,8'h0,8'h0f}, '{0,A,3'h0,8'h0,8'h5e},
    '{1,A,3'h5,8'hff,8'h0}, '{0,A,3'h5,8'h0,8'h61}, '{0,A,3'h6,8'h0,8'ha4},
    '{0,A,3'h2,8'h0,8'h01}, '{1,A,3'h4,8'hff,8'h0}, '{0,A,3'h4,8'h0,8'h1f},
    '{1,A,3'h3,8'h80,8'h0}, '{0,A,3'h0,8'h0,8'h13}, '{0,A,3'h1,8'h0,8'h5a},
    '{1,A,3'h0,8'h12,8'h0}, '{0,A,3'h0,8'h0,8'h12}, '{1,A,3'h1,8'h34,8'h0},
    '{0,A,3'h1,8'h0,8'h34}, '{1,A,3'h3,8'hbf,8'h0}, '{1,A,3'h2,8'h10,8'h0},
    '{0,A,3'h2,8'h0,8'h10}, '{1,A,3'h4,8'h11,8'h0}, '{0,A,3'h4,8'h0,8'h11},
    '{1,A,3'h5,8'h22,8'h0}, '{0,A,3'h5,8'h0,8'h22}, '{1,A,3'h6,8'h33,8'h0},
    '{0,A,3'h6,8'h0,8'h33}, '{1,A,3'h7,8'h44,8'h0}, '{0,A,3'h7,8'h0,8'h44},
    '{1,A,3'h3,8'h80,8'h0}, '{1,A,3'h2,8'hff,8'h0}, '{0,A,3'h2,8'h0,8'h3f},
    '{1,A,3'h3,8'h00,8'h0}, '{1,A,3'h1,8'hff,8'h0}, '{0,A,3'h1,8'h0,8'hff},
    '{1,A,3'h2,8'hc3,8'h0}, '{0,A,3'h2,8'h0,8'hf1}, '{1,A,3'h0,8'h77,8'h0},
    '{0,A,3'h3,8'h0,8'h00}};
  dum_host_model u_host (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_cs_n(cs_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_wdata(wdata));
  dum_regmap DUT (.i_core_clk(clk), .i_rst(rst), .i_addr(addr), .i_chan_a_select_n(cs_n[0]),
    .i_chan_b_select_n(cs_n[1]), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(wdata), .o_data(rdata),
    .o_data_oe(oe), .i_rx_data(16'h775e), .i_int_source(12'h031), .i_line_flags(16'h6061),
    .i_modem_in(16'hb0a4), .o_tx_data(), .o_tx_load(), .o_rx_read(), .o_source_read(),
    .o_modem_in_read(), .o_rx_fifo_reset(), .o_tx_fifo_reset(), .o_line_format(fmt),
    .o_int_mask(), .o_fifo_setup(fifo), .o_modem_out(), .o_divisor_low(dll),
    .o_divisor_high(), .o_divisor_fraction(), .o_features(feat), .o_resume_one(),
    .o_resume_two(), .o_pause_one(), .o_pause_two());
  // Clock at 125 MHz.
  always #4 clk = ~clk;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Watchdog sized well above the expected run of about 200 cycles.
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end
  // Main sequence: reset, table, then second reset in mid-run.
  initial begin
    repeat (6) @(posedge clk);
    check(fmt[7:0], 8'h00);
    #1 rst = 1'b0;
    foreach (rows[i]) begin
      u_host.acc(rows[i].wr, rows[i].cs, rows[i].a, rows[i].d, q);
      if (!rows[i].wr) check(q, rows[i].e);
    end
    check(fifo[7:0], 8'hc1);
    // Hand cases: transmit FIFO pulse, read-only writes, then clearing the enhanced enable.
    u_host.acc(1'b1, A, 3'h2, 8'h04, q);
    check(fifo[7:0], 8'h00);
    u_host.acc(1'b0, A, 3'h2, 8'h00, q);
    check(q, 8'h31);
    u_host.acc(1'b1, A, 3'h6, 8'h00, q);
    u_host.acc(1'b1, A, 3'h5, 8'h00, q);
    u_host.acc(1'b0, A, 3'h6, 8'h00, q);
    check(q, 8'ha4);
    u_host.acc(1'b0, A, 3'h5, 8'h00, q);
    check(q, 8'h61);
    u_host.acc(1'b1, A, 3'h4, 8'hff, q);
    u_host.acc(1'b1, A, 3'h3, 8'hbf, q);
    u_host.acc(1'b1, A, 3'h2, 8'h00, q);
    u_host.acc(1'b1, A, 3'h3, 8'h00, q);
    u_host.acc(1'b0, A, 3'h4, 8'h00, q);
    check(q, 8'h1f);
    u_host.acc(1'b0, A, 3'h1, 8'h00, q);
    check(q, 8'h0f);
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 check(feat[7:0] | dll[7:0] | fmt[7:0], 8'h00);
    rst = 1'b0;
    u_host.acc(1'b0, A, 3'h7, 8'h00, q);
    check(q, 8'h00);
    report_and_stop();
  end
endmodule
bind dum_regmap dum_regmap_checker u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_chan_a_select_n(i_chan_a_select_n), .i_chan_b_select_n(i_chan_b_select_n),
  .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_data(i_data), .i_rx_data(i_rx_data), .o_data(o_data),
  .o_data_oe(o_data_oe), .o_tx_data(o_tx_data), .o_tx_load(o_tx_load), .o_rx_read(o_rx_read),
  .o_source_read(o_source_read), .o_rx_fifo_reset(o_rx_fifo_reset),
  .o_modem_in_read(o_modem_in_read), .o_tx_fifo_reset(o_tx_fifo_reset),
  .o_line_format(o_line_format), .o_int_mask(o_int_mask), .o_modem_out(o_modem_out),
  .o_divisor_low(o_divisor_low), .o_divisor_fraction(o_divisor_fraction),
  .o_features(o_features));
`default_nettype wire
